// *** design/lpds_pkg.sv ***
package lpds_pkg;
  localparam logic [11:0] ADDR_CODE    = 12'h120;
  localparam logic [11:0] ADDR_DAC_SW  = 12'h124;
  localparam logic [11:0] ADDR_CTRL    = 12'h128;
  localparam logic [11:0] ADDR_TIA_SW  = 12'h0e4;
  localparam logic [11:0] ADDR_FE_CTRL = 12'h12c;
  localparam logic [11:0] ADDR_LEVEL   = 12'h130;

  localparam int CODE_FINE_LSB   = 0;
  localparam int CODE_COARSE_LSB = 12;
  localparam int CTRL_AUTO_BIT   = 5;
  localparam int DSW_OVR_BIT     = 5;
  localparam int FE_DCBUF_BIT    = 21;

  localparam logic [17:0] CODE_RST   = 18'h00000;
  localparam logic [5:0]  DSW_RST    = 6'h00;
  localparam logic [5:0]  CTRL_RST   = 6'h02;
  localparam logic [13:0] TSW_RST    = 14'h0000;
  localparam logic [31:0] FE_RST     = 32'h00000000;

  localparam logic [4:0]  PAT_NORMAL = 5'h0c;
  localparam logic [4:0]  PAT_DIAG   = 5'h11;

  localparam logic [11:0] FINE_TOP   = 12'hfff;
  localparam logic [11:0] FINE_CLAMP = 12'hffe;

  // Behavioural output model, microvolts; fine step in nanovolts
  localparam int BASE_UV       = 200000;
  localparam int FINE_STEP_NV  = 540000;
  localparam int COARSE_STEP_UV = 34380;
endpackage

// *** design/lpds_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpds_decode
  import lpds_pkg::*;
(
  input  wire logic        auto_mode,
  input  wire logic [5:0]  dac_sw,
  input  wire logic [17:0] code,
  output logic      [4:0]  sw_pattern,
  output logic      [11:0] fine_eff,
  output logic      [5:0]  coarse_eff
);
  always_comb begin
    if (dac_sw[DSW_OVR_BIT]) begin
      sw_pattern = dac_sw[4:0];
    end else if (auto_mode) begin
      sw_pattern = PAT_DIAG;
    end else begin
      sw_pattern = PAT_NORMAL;
    end
  end

  always_comb begin
    fine_eff   = code[CODE_FINE_LSB +: 12];
    coarse_eff = code[CODE_COARSE_LSB +: 6];
    if (fine_eff == FINE_TOP) begin
      fine_eff = FINE_CLAMP;
    end
  end
endmodule // lpds_decode
`default_nettype wire

// *** design/lpds_top.sv ***
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lpds_top
  import lpds_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [4:0]  dac_sw_out,
  output logic      [13:0] tia_sw_out,
  output logic      [11:0] fine_code_out,
  output logic      [5:0]  coarse_code_out,
  output logic             dc_buffer_en
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [17:0] code_q, code_d;
  logic [5:0]  dsw_q, dsw_d;
  logic [5:0]  ctrl_q, ctrl_d;
  logic [13:0] tsw_q, tsw_d;
  logic [31:0] fe_q, fe_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [4:0]  dsw_out_q, dsw_out_d;
  logic [13:0] tsw_out_q, tsw_out_d;
  logic [11:0] fine_q, fine_d;
  logic [5:0]  coarse_q, coarse_d;
  logic        dcbuf_q, dcbuf_d;
  logic        level_bump;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == ADDR_CODE) || (a == ADDR_DAC_SW) || (a == ADDR_CTRL) ||
                 (a == ADDR_TIA_SW) || (a == ADDR_FE_CTRL) || (a == ADDR_LEVEL);
  endfunction

  wire logic setup  = psel && !penable;
  wire logic access = psel && penable && pready_q;
  wire logic wr     = access && pwrite && known_addr(paddr);

  // ------------------------------------------------------------
  // APB slave: no wait states, pready in access phase
  // ------------------------------------------------------------
  always_comb begin
    code_d    = code_q;
    dsw_d     = dsw_q;
    ctrl_d    = ctrl_q;
    tsw_d     = tsw_q;
    fe_d      = fe_q;
    prdata_d  = prdata_q;
    pready_d  = setup;
    pslverr_d = setup && !known_addr(paddr);
    if (wr) begin
      unique case (paddr)
        ADDR_CODE:    code_d = pwdata[17:0];
        ADDR_DAC_SW:  dsw_d  = pwdata[5:0];
        ADDR_CTRL:    ctrl_d = pwdata[5:0];
        ADDR_TIA_SW:  tsw_d  = pwdata[13:0];
        ADDR_FE_CTRL: fe_d   = pwdata;
        default:      ;
      endcase
    end
    if (setup && !pwrite) begin
      unique case (paddr)
        ADDR_CODE:    prdata_d = {14'h0000, code_q};
        ADDR_DAC_SW:  prdata_d = {26'h0000000, dsw_q};
        ADDR_CTRL:    prdata_d = {26'h0000000, ctrl_q};
        ADDR_TIA_SW:  prdata_d = {18'h00000, tsw_q};
        ADDR_FE_CTRL: prdata_d = fe_q;
        ADDR_LEVEL:   prdata_d = {13'h0000, level_bump, coarse_q, fine_q};
        default:      prdata_d = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Switch decode
  // ------------------------------------------------------------
  lpds_decode u_decode (
    .auto_mode  (ctrl_q[CTRL_AUTO_BIT]),
    .dac_sw     (dsw_q),
    .code       (code_q),
    .sw_pattern (dsw_out_d),
    .fine_eff   (fine_d),
    .coarse_eff (coarse_d)
  );

  // ------------------------------------------------------------
  // Output stage next values
  // ------------------------------------------------------------
  // Every output sits one edge behind its register, so all switches
  // of one write move on the same edge
  always_comb begin
    tsw_out_d  = tsw_q;
    dcbuf_d    = fe_q[FE_DCBUF_BIT];
    // Fine level at or above the coarse level sets level_bump, bit 18 of the level readback
    level_bump = (fine_q >= {coarse_q, 6'h00});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q    <= CODE_RST;
      dsw_q     <= DSW_RST;
      ctrl_q    <= CTRL_RST;
      tsw_q     <= TSW_RST;
      fe_q      <= FE_RST;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      dsw_out_q <= PAT_NORMAL;
      tsw_out_q <= TSW_RST;
      fine_q    <= 12'h000;
      coarse_q  <= 6'h00;
      dcbuf_q   <= 1'b0;
    end else if (clk_en) begin
      code_q    <= code_d;
      dsw_q     <= dsw_d;
      ctrl_q    <= ctrl_d;
      tsw_q     <= tsw_d;
      fe_q      <= fe_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      dsw_out_q <= dsw_out_d;
      tsw_out_q <= tsw_out_d;
      fine_q    <= fine_d;
      coarse_q  <= coarse_d;
      dcbuf_q   <= dcbuf_d;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign dac_sw_out      = dsw_out_q;
  assign tia_sw_out      = tsw_out_q;
  assign fine_code_out   = fine_q;
  assign coarse_code_out = coarse_q;
  assign dc_buffer_en    = dcbuf_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ovr_off;
    clk_en && !dsw_q[DSW_OVR_BIT];
  endsequence

  a_normal_pattern: assert property (s_ovr_off and !ctrl_q[CTRL_AUTO_BIT] |=> dac_sw_out == 5'h0c)
    else $error("normal pattern wrong");
  a_diag_pattern: assert property (s_ovr_off and ctrl_q[CTRL_AUTO_BIT] |=> dac_sw_out == 5'h11)
    else $error("diagnostic pattern wrong");
  a_override_bits: assert property (clk_en && dsw_q[DSW_OVR_BIT] |=> dac_sw_out == $past(dsw_q[4:0]))
    else $error("override pattern wrong");
  a_tia_follow: assert property (wr && paddr == ADDR_TIA_SW ##1 clk_en |=> tia_sw_out == $past(pwdata[13:0], 2))
    else $error("tia switches not following write");
  a_code_fields: assert property (clk_en && wr && paddr == ADDR_CODE |=> code_q[17:12] == $past(pwdata[17:12]))
    else $error("coarse code field wrong");
  a_top_clamp: assert property (clk_en && code_q[11:0] == 12'hfff |=> fine_code_out == 12'hffe)
    else $error("top code not clamped");
  a_reset_vals: assert property ($rose(presetn) |-> dsw_q == 6'h00 && ctrl_q == 6'h02)
    else $error("reset values wrong");
  a_apb_answer: assert property (setup && clk_en ##1 clk_en |-> pready)
    else $error("pready not given after setup");

  // ------------------------------------------------------------
  // Bus, freeze, dc buffer and clamp checks
  // ------------------------------------------------------------
  sequence s_setup_bad;
    clk_en && setup && !known_addr(paddr);
  endsequence

  sequence s_setup_read;
    clk_en && setup && !pwrite;
  endsequence

  a_bad_addr_err: assert property (s_setup_bad |=> pready && pslverr)
    else $error("unmapped access without error");
  a_ctrl_readback: assert property (s_setup_read and paddr == ADDR_CTRL |=> prdata == {26'h0000000, $past(ctrl_q)})
    else $error("control readback wrong");
  a_code_readback: assert property (s_setup_read and paddr == ADDR_CODE |=> prdata == {14'h0000, $past(code_q)})
    else $error("code readback wrong");
  a_tsw_readback: assert property (s_setup_read and paddr == ADDR_TIA_SW |=> prdata == {18'h00000, $past(tsw_q)})
    else $error("tia switch readback wrong");
  a_unmapped_keep: assert property (clk_en && access && pwrite && !known_addr(paddr) |=> $stable(dsw_q) && $stable(ctrl_q) && $stable(tsw_q))
    else $error("unmapped write changed state");
  a_freeze_outs: assert property (!clk_en |=> $stable(dac_sw_out) && $stable(tia_sw_out) && $stable(fine_code_out))
    else $error("outputs moved while frozen");
  a_pready_pulse: assert property (clk_en && pready |=> !pready)
    else $error("pready longer than one cycle");
  a_dcbuf_follow: assert property (clk_en |=> dc_buffer_en == $past(fe_q[FE_DCBUF_BIT]))
    else $error("dc buffer enable not following register");
  a_clamp_only_top: assert property (clk_en && code_q[11:0] != 12'hfff |=> fine_code_out == $past(code_q[11:0]))
    else $error("fine code changed below top");
endmodule // lpds_top
`default_nettype wire

// *** bench/tb_low_power_dac_switch_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_low_power_dac_switch_control;
  import lpds_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dc_buffer_en;
  logic [11:0] paddr, fine_code_out;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0]  dac_sw_out;
  logic [13:0] tia_sw_out;
  logic [5:0]  coarse_code_out;
  logic        err, clk_en;
  int          n_mismatch = 0, comparisons = 0, cyc = 0;
  logic [13:0] pats [8] = '{14'h302c, 14'h302d, 14'h302e, 14'h306c, 14'h342c, 14'h0014, 14'h0094, 14'h04a4};

  lpds_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dac_sw_out(dac_sw_out), .tia_sw_out(tia_sw_out),
    .fine_code_out(fine_code_out), .coarse_code_out(coarse_code_out), .dc_buffer_en(dc_buffer_en));

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Bus access tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(negedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      @(negedge pclk);
    end
    rdat = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000; pwdata = 32'h0; clk_en = 1;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_CTRL, 32'h00000002);
    rd(ADDR_DAC_SW, 32'h00000000);
    `CHK(dac_sw_out, 5'h0c)
    $display("test reset done");
    wr(ADDR_CTRL, 32'h00000022);
    `CHK(dac_sw_out, 5'h11)
    wr(ADDR_DAC_SW, 32'h00000032);
    `CHK(dac_sw_out, 5'h12)
    wr(ADDR_DAC_SW, 32'h00000031);
    `CHK(dac_sw_out, 5'h11)
    wr(ADDR_CTRL, 32'h00000002);
    `CHK(dac_sw_out, 5'h11)
    wr(ADDR_DAC_SW, 32'h00000011);
    `CHK(dac_sw_out, 5'h0c)
    $display("test dac switches done");
    foreach (pats[i]) begin
      wr(ADDR_TIA_SW, {18'h0, pats[i]});
      `CHK(tia_sw_out, pats[i])
      rd(ADDR_TIA_SW, {18'h0, pats[i]});
    end
    apb(1'b1, ADDR_TIA_SW, 32'h00001234);
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(tia_sw_out, 14'h04a4)
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(tia_sw_out, 14'h1234)
    $display("test tia switches done");
    wr(ADDR_CODE, 32'h00005fff);
    `CHK(fine_code_out, 12'hffe)
    `CHK(coarse_code_out, 6'h05)
    rd(ADDR_CODE, 32'h00005fff);
    rd(ADDR_LEVEL, 32'h00045ffe);
    wr(ADDR_CODE, 32'h0003f7ab);
    rd(ADDR_LEVEL, 32'h0003f7ab);
    `CHK(fine_code_out, 12'h7ab)
    `CHK(coarse_code_out, 6'h3f)
    $display("test codes done");
    wr(ADDR_FE_CTRL, 32'h00200000);
    `CHK(dc_buffer_en, 1'b1)
    wr(ADDR_FE_CTRL, 32'h00000000);
    `CHK(dc_buffer_en, 1'b0)
    rd(12'hff0, 32'h00000000);
    `CHK(err, 1'b1)
    $display("test front end and unmapped done");
    give_verdict();
  end
endmodule // tb_low_power_dac_switch_control
`default_nettype wire
